// ### core/msgstat_params.svh
// Constants for the message, status and sense handling block
`ifndef MSGSTAT_PARAMS_SVH
`define MSGSTAT_PARAMS_SVH
// Message codes
`define MSG_CMD_COMPLETE 8'h00
`define MSG_EXTENDED 8'h01
`define MSG_SAVE_PTR 8'h02
`define MSG_DISCONNECT 8'h04
`define MSG_ABORT 8'h06
`define MSG_REJECT 8'h07
`define MSG_DEV_RESET 8'h0c
`define MSG_IDENTIFY 8'h80
// Status codes in bits 4..1
`define STAT_GOOD 4'h0
`define STAT_CHECK 4'h1
// Sense keys
`define SENSE_NONE 4'h0
`define SENSE_ILLEGAL 4'h5
`define SENSE_ERROR 4'h9
`define SENSE_ABORTED 4'hb
// Request sense opcode and sense byte holding the key
`define OP_REQ_SENSE 8'h03
`define SENSE_KEY_BYTE 8'h02
// Command/status buffer depth
`define CSB_DEPTH 8
`define CSB_AW 3
// Register offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SENSE 8'h08
`define REG_CSB_CNT 8'h0c
`define REG_CSB_DATA 8'h10
`define REG_MSG_OUT 8'h14
// CTRL fields
`define CTRL_MODE_BIT 0
`define CTRL_RESET 8'h00
`endif

// ### core/msgstat_pkg.sv
// Types for the message, status and sense handling block
package msgstat_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_STATUS = 3'b001,
		ST_COMPLETE = 3'b010,
		ST_SAVEPTR = 3'b011,
		ST_DISC = 3'b100,
		ST_IDENT = 3'b101,
		ST_REJECT = 3'b110,
		ST_EXT = 3'b111
	} tgt_state_t;
endpackage : msgstat_pkg

// ### core/msgstat_core.sv
// Message, status byte and sense key handling of the bus-side controller
`timescale 1ns/1ps
`include "msgstat_params.svh"

// Overview of operation
// - Target mode status byte bits 7, 6, 5 forced to zero; code in bits 4..1.
// - Status bit 0 set after read when end seen, else cleared.
// - Status code 0000 when command finished without error.
// - Status code 0001 on error; initiator then requests sense, opcode 3.
// - Target mode sends message 0 when the command is done.
// - Initiator mode stores received command complete in the buffer only.
// - Message 1 leads a multi-byte message, only in continuous status.
// - Message 2 is sent before every disconnect message.
// - Message 4 is sent before releasing the bus.
// - Initiator mode: busy loss after disconnect is no error; await reconnection.
// - Disconnected command leaves 0x04 and 0x80 ahead of status and message.
// - Received abort kills a pending disconnected command, else no effect.
// - Initiator mode sends abort to stop the command in progress.
// - Unknown or improper received message answered by message reject.
// - Received bus device reset handled exactly as abort.
// - Initiator mode sends bus device reset to clear a target.
// - Identify sent right after reconnection; received identify enables disconnect.
// - Initiator mode sends identify; received identify stored and ends the reselection wait.
// - Sense key placed in byte 2 of the sense data.
// - Sense key 0 after success, 5 for illegal opcode or parameter.
// - Sense key 9 when the last command hit an error.
// - Sense key 11 after an aborted command; initiator may retry.
// - Initiator mode makes no status or sense of its own, passes target's.
module msgstat_core (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Target mode command events
	input wire logic i_cmd_done,
	input wire logic i_cmd_err,
	input wire logic i_cmd_illegal,
	input wire logic i_read_cmd,
	input wire logic i_block_read_cmd,
	input wire logic i_stat_cmd,
	input wire logic i_read_end,
	input wire logic i_want_disc,
	input wire logic i_reconnect,
	input wire logic i_cont_status,
	input wire logic [7:0] i_sense_idx,
	// Received message bytes
	input wire logic i_msg_in_vld,
	input wire logic [7:0] i_msg_in,
	// Initiator mode events
	input wire logic i_stat_in_vld,
	input wire logic [7:0] i_stat_in,
	input wire logic i_bsy_lost,
	input wire logic i_send_abort,
	input wire logic i_send_reset,
	input wire logic i_send_ident,
	// Outgoing bytes
	output logic o_msg_vld,
	output logic [7:0] o_msg,
	output logic o_stat_vld,
	output logic [7:0] o_stat,
	output logic [7:0] o_sense_byte,
	output logic o_aborted,
	output logic o_bus_err,
	output logic o_await_resel
);

	typedef struct packed {
		logic init_mode;
		msgstat_pkg::tgt_state_t st;
		logic [3:0] code;
		logic end_bit;
		logic [3:0] sense;
		logic disc_ok;
		logic pending;
		logic cont;
		logic await;
		logic [`CSB_DEPTH-1:0][7:0] csb;
		logic [`CSB_AW:0] cnt;
		logic [`CSB_AW-1:0] rptr;
		logic [31:0] rdata;
		logic msg_vld;
		logic [7:0] msg;
		logic stat_vld;
		logic [7:0] stat;
		logic [7:0] sense_byte;
		logic aborted;
		logic bus_err;
	} state_t;

	state_t r, nxt;
	logic known;
	logic kill;

	// Known received message set
	always_comb begin
		known = (i_msg_in == `MSG_ABORT) || (i_msg_in == `MSG_DEV_RESET) || i_msg_in[7];
		kill = i_msg_in_vld && !r.init_mode &&
			((i_msg_in == `MSG_ABORT) || (i_msg_in == `MSG_DEV_RESET));
	end

	always_comb begin
		nxt = r;
		nxt.msg_vld = 1'b0;
		nxt.stat_vld = 1'b0;
		// Register writes
		if (i_wr && i_addr == `REG_CTRL) begin
			nxt.init_mode = i_wdata[`CTRL_MODE_BIT];
		end
		if (i_wr && i_addr == `REG_MSG_OUT && r.init_mode) begin
			nxt.msg_vld = 1'b1;
			nxt.msg = i_wdata[7:0];
		end
		// Register reads, data in the next cycle
		nxt.rdata = 32'h0;
		if (i_rd) begin
			case (i_addr)
				`REG_CTRL: nxt.rdata = {31'h0, r.init_mode};
				`REG_STATUS: nxt.rdata = {24'h0, r.await, r.disc_ok, r.pending,
					r.code, r.end_bit};
				`REG_SENSE: nxt.rdata = {28'h0, r.sense};
				`REG_CSB_CNT: nxt.rdata = {28'h0, r.cnt};
				`REG_CSB_DATA: nxt.rdata = {24'h0, r.csb[r.rptr]};
				default: nxt.rdata = 32'h0;
			endcase
		end
		if (i_rd && i_addr == `REG_CSB_DATA && r.cnt != '0) begin
			nxt.rptr = r.rptr + 1'b1;
			nxt.cnt = r.cnt - 1'b1;
		end
		if (i_wr && i_addr == `REG_CSB_CNT) begin
			nxt.cnt = '0;
			nxt.rptr = '0;
		end
		if (r.init_mode) begin
			// Initiator mode: bytes from target stored; disconnect sets and identify clears await
			if ((i_msg_in_vld || i_stat_in_vld) && nxt.cnt != `CSB_DEPTH) begin
				nxt.csb[(nxt.rptr + nxt.cnt[`CSB_AW-1:0])] = i_msg_in_vld ? i_msg_in : i_stat_in;
				nxt.cnt = nxt.cnt + 1'b1;
			end
			if (i_msg_in_vld && i_msg_in == `MSG_DISCONNECT) begin
				nxt.await = 1'b1;
			end
			if (i_msg_in_vld && i_msg_in[7]) begin
				nxt.await = 1'b0;
			end
			nxt.bus_err = i_bsy_lost && !r.await;
			if (i_send_abort) begin
				nxt.msg_vld = 1'b1;
				nxt.msg = `MSG_ABORT;
			end else if (i_send_reset) begin
				nxt.msg_vld = 1'b1;
				nxt.msg = `MSG_DEV_RESET;
			end else if (i_send_ident) begin
				nxt.msg_vld = 1'b1;
				nxt.msg = `MSG_IDENTIFY;
			end
		end else begin
			nxt.bus_err = 1'b0;
			nxt.aborted = 1'b0;
			if (i_msg_in_vld && i_msg_in[7]) begin
				nxt.disc_ok = 1'b1;
			end
			if (kill && r.pending) begin
				nxt.pending = 1'b0;
				nxt.aborted = 1'b1;
				nxt.sense = `SENSE_ABORTED;
				nxt.code = `STAT_CHECK;
			end
			if (i_read_cmd || i_block_read_cmd) begin
				nxt.end_bit = i_read_end;
			end
			if (i_cont_status) begin
				nxt.cont = 1'b1;
			end
			case (r.st)
				msgstat_pkg::ST_IDLE: begin
					if (i_msg_in_vld && !known) begin
						nxt.st = msgstat_pkg::ST_REJECT;
					end else if (i_want_disc && r.disc_ok) begin
						nxt.pending = 1'b1;
						nxt.st = msgstat_pkg::ST_SAVEPTR;
					end else if (i_reconnect && r.pending) begin
						nxt.pending = 1'b0;
						nxt.st = msgstat_pkg::ST_IDENT;
					end else if (i_cmd_done) begin
						nxt.code = (i_cmd_err || i_cmd_illegal) ? `STAT_CHECK : `STAT_GOOD;
						nxt.sense = i_cmd_illegal ? `SENSE_ILLEGAL :
							i_cmd_err ? `SENSE_ERROR : `SENSE_NONE;
						nxt.st = msgstat_pkg::ST_STATUS;
					end else if (i_stat_cmd) begin
						nxt.st = msgstat_pkg::ST_STATUS;
					end
				end
				msgstat_pkg::ST_STATUS: begin
					nxt.stat_vld = 1'b1;
					nxt.stat = {3'b000, r.code, r.end_bit};
					nxt.st = r.cont ? msgstat_pkg::ST_EXT : msgstat_pkg::ST_COMPLETE;
				end
				msgstat_pkg::ST_EXT: begin
					nxt.msg_vld = 1'b1;
					nxt.msg = `MSG_EXTENDED;
					nxt.cont = 1'b0;
					nxt.st = msgstat_pkg::ST_COMPLETE;
				end
				msgstat_pkg::ST_COMPLETE: begin
					nxt.msg_vld = 1'b1;
					nxt.msg = `MSG_CMD_COMPLETE;
					nxt.st = msgstat_pkg::ST_IDLE;
				end
				msgstat_pkg::ST_SAVEPTR: begin
					nxt.msg_vld = 1'b1;
					nxt.msg = `MSG_SAVE_PTR;
					nxt.st = msgstat_pkg::ST_DISC;
				end
				msgstat_pkg::ST_DISC: begin
					nxt.msg_vld = 1'b1;
					nxt.msg = `MSG_DISCONNECT;
					nxt.st = msgstat_pkg::ST_IDLE;
				end
				msgstat_pkg::ST_IDENT: begin
					nxt.msg_vld = 1'b1;
					nxt.msg = `MSG_IDENTIFY;
					nxt.st = msgstat_pkg::ST_IDLE;
				end
				msgstat_pkg::ST_REJECT: begin
					nxt.msg_vld = 1'b1;
					nxt.msg = `MSG_REJECT;
					nxt.st = msgstat_pkg::ST_IDLE;
				end
				default: nxt.st = msgstat_pkg::ST_IDLE;
			endcase
			// Sense byte lookup for request sense data
			nxt.sense_byte = (i_sense_idx == `SENSE_KEY_BYTE) ? {4'h0, nxt.sense} : 8'h00;
		end
		if (r.init_mode) begin
			nxt.sense_byte = 8'h00;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			r <= '0;
		end else if (i_ce) begin
			r <= nxt;
		end
	end

	// Outputs from flip-flops
	always_comb begin
		o_rdata = r.rdata;
		o_msg_vld = r.msg_vld;
		o_msg = r.msg;
		o_stat_vld = r.stat_vld;
		o_stat = r.stat;
		o_sense_byte = r.sense_byte;
		o_aborted = r.aborted;
		o_bus_err = r.bus_err;
		o_await_resel = r.await;
	end

	a_status_top_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_stat_vld
		|-> o_stat[7:5] == 3'b000)
		else $error("status top bits set");

	a_complete_after_stat: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(o_stat_vld && i_ce && !r.cont && !r.init_mode)
		|=> (o_msg_vld && o_msg == 8'h00))
		else $error("no complete after status");

	a_disc_after_save: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(o_msg_vld && o_msg == 8'h02 && i_ce && !r.init_mode)
		|=> (o_msg_vld && o_msg == 8'h04))
		else $error("disconnect missing after save");

	a_no_busy_err: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(r.init_mode && r.await && i_ce)
		|=> !o_bus_err)
		else $error("busy loss flagged");

	a_good_code: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(r.st == msgstat_pkg::ST_IDLE && i_cmd_done && !i_cmd_err && !i_cmd_illegal && i_ce
		&& !r.init_mode && !i_msg_in_vld && !i_want_disc && !i_reconnect)
		|=> ##1 (o_stat_vld && o_stat[4:1] == 4'h0)) else $error("good code wrong");

	a_abort_sense: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(kill && r.pending && i_ce)
		|=> (o_aborted && r.sense == 4'hb))
		else $error("abort sense wrong");

	a_reject_unknown: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(r.st == msgstat_pkg::ST_IDLE && i_msg_in_vld && !known && !r.init_mode && i_ce)
		|=> ##1 (o_msg_vld && o_msg == 8'h07))
		else $error("no reject");

	a_init_abort_send: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(r.init_mode && i_send_abort && i_ce && !i_wr)
		|=> (o_msg_vld && o_msg == 8'h06))
		else $error("abort not sent");

	a_ext_before_cmpl: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(o_stat_vld && i_ce && r.cont && !r.init_mode)
		|=> (o_msg_vld && o_msg == 8'h01))
		else $error("extended message missing");

	a_save_then_disc: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(o_msg_vld && o_msg == 8'h04 && !r.init_mode && $past(i_ce))
		|-> ($past(o_msg_vld) && $past(o_msg) == 8'h02))
		else $error("disconnect without save");

	a_ident_reconnect: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(r.st == msgstat_pkg::ST_IDLE && i_reconnect && r.pending && i_ce && !r.init_mode
		&& !i_msg_in_vld && !i_want_disc)
		|=> ##1 (o_msg_vld && o_msg == 8'h80)) else $error("identify missing");

	a_init_no_status: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(r.init_mode && i_ce)
		|=> !o_stat_vld)
		else $error("status made in initiator mode");

	a_init_sense_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(r.init_mode && i_ce)
		|=> o_sense_byte == 8'h00)
		else $error("sense made in initiator mode");

	a_end_bit_load: assert property (@(posedge i_clk) disable iff (!i_rstn)
		((i_read_cmd || i_block_read_cmd) && !r.init_mode && i_ce)
		|=> r.end_bit == $past(i_read_end))
		else $error("end bit not loaded");

	a_sense_key_byte: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(!r.init_mode && i_ce && i_sense_idx != 8'h02)
		|=> o_sense_byte == 8'h00)
		else $error("sense key outside byte 2");

	a_abort_idle_none: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(kill && !r.pending && i_ce)
		|=> !o_aborted)
		else $error("abort with nothing pending");

	a_reset_kill: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(kill && r.pending && i_msg_in == 8'h0c && !i_want_disc && i_ce)
		|=> (!r.pending && r.sense == 4'hb))
		else $error("device reset not as abort");

	a_reset_send: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(r.init_mode && i_send_reset && !i_send_abort && i_ce)
		|=> (o_msg_vld && o_msg == 8'h0c))
		else $error("device reset not sent");

	a_ident_send: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(r.init_mode && i_send_ident && !i_send_abort && !i_send_reset && i_ce)
		|=> (o_msg_vld && o_msg == 8'h80))
		else $error("identify not sent");

	a_check_code: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(r.st == msgstat_pkg::ST_IDLE && i_cmd_done && i_cmd_err && i_ce && !r.init_mode
		&& !i_msg_in_vld && !i_want_disc && !i_reconnect)
		|=> ##1 (o_stat_vld && o_stat[4:1] == 4'h1)) else $error("check code wrong");

	a_sense_none: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(r.st == msgstat_pkg::ST_IDLE && i_cmd_done && !i_cmd_err && !i_cmd_illegal && i_ce
		&& !r.init_mode && !i_msg_in_vld && !i_want_disc && !i_reconnect)
		|=> r.sense == 4'h0) else $error("sense not cleared");

	a_busy_err_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(r.init_mode && !r.await && i_bsy_lost && i_ce)
		|=> o_bus_err)
		else $error("busy loss not flagged");

	a_csb_store: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(r.init_mode && i_msg_in_vld && r.cnt != 4'h8 && !i_rd && !i_wr && i_ce)
		|=> r.cnt == $past(r.cnt) + 4'h1)
		else $error("message byte not stored");

endmodule : msgstat_core

// ### test/scsi_far_model.sv
// Far-side model: logs bytes sent by the block, delivers message bytes to it
`timescale 1ns/1ps
module scsi_far_model (
	// Clock
	input wire logic i_clk,
	// Bytes from the block
	input wire logic i_msg_vld,
	input wire logic [7:0] i_msg,
	input wire logic i_stat_vld,
	input wire logic [7:0] i_stat,
	// Bytes to the block
	output logic o_msg_vld,
	output logic [7:0] o_msg
);
	logic [8:0] log_q[$];
	initial begin
		o_msg_vld = 1'b0;
		o_msg = 8'h5a;
	end
	// Status bytes flagged by bit 8
	always @(posedge i_clk) begin
		if (i_stat_vld === 1'b1) log_q.push_back({1'b1, i_stat});
		if (i_msg_vld === 1'b1) log_q.push_back({1'b0, i_msg});
	end
	// One message byte, then the line shows the inverse
	task put_msg(input logic [7:0] b);
		o_msg_vld <= 1'b1;
		o_msg <= b;
		@(posedge i_clk);
		o_msg_vld <= 1'b0;
		o_msg <= ~b;
	endtask : put_msg
endmodule : scsi_far_model

// ### test/scsi_message_status_sense_bench.sv
// Self-checking bench for the message, status and sense block
`timescale 1ns/1ps
`include "msgstat_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
	$display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module scsi_message_status_sense_bench;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [11:0] ev = 12'h000;
	logic i_cmd_done, i_read_cmd, i_block_read_cmd, i_stat_cmd, i_want_disc, i_reconnect;
	logic i_cont_status, i_bsy_lost, i_send_abort, i_send_reset, i_send_ident, i_stat_in_vld;
	logic i_cmd_err = 1'b0, i_cmd_illegal = 1'b0, i_read_end = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic [7:0] i_addr = 8'h00, i_sense_idx = 8'h02, i_stat_in = 8'h00;
	logic [31:0] i_wdata = 32'h0, o_rdata, d;
	logic i_msg_in_vld, o_msg_vld, o_stat_vld, o_aborted, o_bus_err, o_await_resel;
	logic [7:0] i_msg_in, o_msg, o_stat, o_sense_byte;
	logic [7:0] csb_exp[4] = '{8'h04, 8'h80, 8'h02, 8'h00};
	int fail_count = 0, checked = 0, cyc = 0, n_ab = 0, n_err = 0;
	assign {i_cmd_done, i_read_cmd, i_block_read_cmd, i_stat_cmd, i_want_disc, i_reconnect,
		i_cont_status, i_bsy_lost, i_send_abort, i_send_reset, i_send_ident, i_stat_in_vld} = ev;
	always #4 i_clk = ~i_clk;
	msgstat_core u_dut (.i_clk, .i_rstn, .i_ce(1'b1), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_cmd_done, .i_cmd_err, .i_cmd_illegal, .i_read_cmd, .i_block_read_cmd, .i_stat_cmd,
		.i_read_end, .i_want_disc, .i_reconnect, .i_cont_status, .i_sense_idx, .i_msg_in_vld,
		.i_msg_in, .i_stat_in_vld, .i_stat_in, .i_bsy_lost, .i_send_abort, .i_send_reset,
		.i_send_ident, .o_msg_vld, .o_msg, .o_stat_vld, .o_stat, .o_sense_byte, .o_aborted,
		.o_bus_err, .o_await_resel);
	scsi_far_model u_far (.i_clk, .i_msg_vld(o_msg_vld), .i_msg(o_msg), .i_stat_vld(o_stat_vld),
		.i_stat(o_stat), .o_msg_vld(i_msg_in_vld), .o_msg(i_msg_in));
	// Pulse counters and hang guard
	always @(posedge i_clk) begin
		cyc++;
		if (o_aborted === 1'b1) n_ab++;
		if (o_bus_err === 1'b1) n_err++;
		if (cyc == 3000) begin
			fail_count++;
			give_verdict();
		end
	end
	task tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tick
	task run(input logic [11:0] m);
		ev <= m;
		tick(1);
		ev <= 12'h000;
		tick(6);
	endtask : run
	task msg(input logic [7:0] b);
		u_far.put_msg(b);
		tick(6);
	endtask : msg
	task wr(input logic [7:0] a, input logic [31:0] v);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		tick(1);
		i_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		i_rd <= 1'b1;
		i_addr <= a;
		tick(1);
		i_rd <= 1'b0;
		#1 d = o_rdata;
		tick(1);
	endtask : rd
	task chk_log(input logic [8:0] e[$]);
		`CHK(u_far.log_q.size(), e.size())
		foreach (e[i]) if (i < u_far.log_q.size()) `CHK(u_far.log_q[i], e[i])
		u_far.log_q.delete();
	endtask : chk_log
	task give_verdict();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict
	initial begin
		tick(2);
		i_rstn <= 1'b1;
		tick(1);
		rd(`REG_STATUS);
		`CHK(d, 32'h0)
		rd(8'h40);
		`CHK(d, 32'h0)
		// Target role: good, error, illegal
		run(12'h800);
		chk_log('{9'h100, 9'h000});
		`CHK(o_sense_byte, 8'h00)
		i_cmd_err <= 1'b1;
		run(12'h800);
		chk_log('{9'h102, 9'h000});
		`CHK(o_sense_byte, 8'h09)
		i_sense_idx <= 8'h01;
		tick(2);
		`CHK(o_sense_byte, 8'h00)
		i_sense_idx <= 8'h02;
		i_cmd_err <= 1'b0;
		i_cmd_illegal <= 1'b1;
		run(12'h800);
		chk_log('{9'h102, 9'h000});
		`CHK(o_sense_byte, 8'h05)
		rd(`REG_SENSE);
		`CHK(d, 32'h5)
		i_cmd_illegal <= 1'b0;
		// End bit after reads and status queries
		i_read_end <= 1'b1;
		run(12'h400);
		run(12'h800);
		chk_log('{9'h101, 9'h000});
		run(12'h100);
		`CHK(u_far.log_q[0], 9'h101)
		u_far.log_q.delete();
		i_read_end <= 1'b0;
		run(12'h200);
		run(12'h800);
		chk_log('{9'h100, 9'h000});
		run(12'h020);
		run(12'h800);
		chk_log('{9'h100, 9'h001, 9'h000});
		// Messages, disconnect, reconnect, abort
		msg(8'h2a);
		chk_log('{9'h007});
		msg(8'h80);
		`CHK(u_far.log_q.size(), 0)
		run(12'h080);
		chk_log('{9'h002, 9'h004});
		run(12'h040);
		chk_log('{9'h080});
		run(12'h080);
		msg(8'h06);
		`CHK(n_ab, 1)
		`CHK(o_sense_byte, 8'h0b)
		run(12'h080);
		msg(8'h0c);
		`CHK(n_ab, 2)
		u_far.log_q.delete();
		msg(8'h06);
		`CHK(n_ab, 2)
		`CHK(u_far.log_q.size(), 0)
		// Initiator role
		wr(`REG_CTRL, 32'h1);
		run(12'h008);
		run(12'h004);
		run(12'h002);
		wr(`REG_MSG_OUT, 32'h0000000c);
		tick(3);
		chk_log('{9'h006, 9'h00c, 9'h080, 9'h00c});
		wr(`REG_CSB_CNT, 32'h0);
		run(12'h010);
		`CHK(n_err, 1)
		msg(8'h04);
		`CHK(o_await_resel, 1'b1)
		run(12'h010);
		`CHK(n_err, 1)
		msg(8'h80);
		i_stat_in <= 8'h02;
		run(12'h001);
		msg(8'h00);
		rd(`REG_CSB_CNT);
		`CHK(d[7:0], 8'h04)
		for (int i = 0; i < 4; i++) begin
			rd(`REG_CSB_DATA);
			`CHK(d[7:0], csb_exp[i])
		end
		`CHK(u_far.log_q.size(), 0)
		give_verdict();
	end
endmodule : scsi_message_status_sense_bench
